// File: include/supervisor_regs.svh
// timing constants and default values for the supervisory reset watchdog
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH
`define CLK_SYS_MHZ        125
`define STROBE_PERIOD_MS   20
`define WDT_TIMEOUT_MS     30
`define WDT_TIMEOUT_CYC    (`WDT_TIMEOUT_MS * 1000 * `CLK_SYS_MHZ)
`define RST_PULSE_CYC      16
`define SETTLE_DEFAULT_CYC 1024
`define CFG_DEFAULT        16'h0000
`endif

// File: include/supervisor_pkg.sv
// types shared by the supervisory reset watchdog
package supervisor_pkg;
    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_RESET  = 2'b01,
        ST_SETTLE = 2'b10
    } sup_state_t;
endpackage

// File: rtl/supervisor_reset_watchdog.sv
// supervisory reset: watchdog, brownout request, loopback init and result-valid flag
`include "supervisor_regs.svh"

// Summary of operation
// - firmware strobes watchdog every 20 ms
// - missing strobes start a device reset
// - brownout indication resets the processor
// - any reset restores power-up configuration
// - result-valid reads 1 once data valid
// - high reset input initializes; output active high
module supervisor_reset_watchdog #(
    parameter int unsigned WDT_TIMEOUT_CYC = `WDT_TIMEOUT_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        wdt_strobe,
    input  wire logic        brownout,
    input  wire logic        reset_in,
    input  wire logic        cfg_wr,
    input  wire logic [15:0] cfg_wdata,
    input  wire logic [15:0] settle_cycles,
    input  wire logic        data_ready,
    output logic             reset_out,
    output logic [15:0]      cfg_value,
    output logic [7:0]       conversion_status_byte
);
    supervisor_pkg::sup_state_t state_q;
    supervisor_pkg::sup_state_t state_d;
    logic [31:0] wdt_cnt_q;
    logic [4:0]  pulse_cnt_q;
    logic [15:0] settle_cnt_q;
    logic        valid_q;

    localparam logic [31:0] WDT_LIMIT = 32'(WDT_TIMEOUT_CYC - 1);
    localparam logic [4:0]  PULSE_LAST = 5'(`RST_PULSE_CYC - 1);

    // how the pieces fit together:
    //  - reset_out is a registered copy of "next state is reset", so it rises one
    //    clock after a brownout or a watchdog expiry and stays up for the whole pulse
    //  - the system feeds reset_out back into reset_in, optionally ored with an
    //    external reset; while reset_in is high the configuration, the result-valid
    //    flag and the watchdog count are cleared on every clock
    //  - a brownout holds the pulse open for as long as the supply stays low, so the
    //    processor never restarts on a sagging rail
    //  - after the pulse the block settles: result-valid waits for settle_cycles and
    //    for data_ready, because the time to good data depends on range and integration
    //  - the watchdog count saturates at its limit and never wraps, so a stuck
    //    firmware keeps asking for a reset rather than timing out only once
    //  - the timeout must stay longer than the firmware strobe period, or normal
    //    servicing would reset the device; the margin is set by the parameter
    //  - an external reset alone does not restart the pulse; it only clears the
    //    state that the loopback would clear, and settling starts again after it
    //  - the run state is kept in the type; the block leaves reset into settle

    // reset request sources and init condition
    wire wdt_expired = (wdt_cnt_q == WDT_LIMIT) && !wdt_strobe;
    wire request_rst = wdt_expired || brownout;
    wire init_now    = !rstn || reset_in;
    wire pulse_done  = (pulse_cnt_q == PULSE_LAST);
    wire settle_done = (settle_cnt_q >= settle_cycles) && data_ready;

    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            supervisor_pkg::ST_RUN:    if (request_rst) state_d = supervisor_pkg::ST_RESET;
            supervisor_pkg::ST_RESET:  if (pulse_done && !brownout) state_d = supervisor_pkg::ST_SETTLE;
            supervisor_pkg::ST_SETTLE: if (request_rst) state_d = supervisor_pkg::ST_RESET;
            default:                   state_d = supervisor_pkg::ST_RESET;
        endcase
    end

    // state, reset pulse and watchdog counter
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_q     <= supervisor_pkg::ST_RESET;
            pulse_cnt_q <= 5'h00;
            wdt_cnt_q   <= 32'h0000_0000;
        end else begin
            state_q     <= state_d;
            pulse_cnt_q <= (state_q == supervisor_pkg::ST_RESET && !pulse_done) ? pulse_cnt_q + 5'h01 : 5'h00;
            if (wdt_strobe || reset_in || state_q == supervisor_pkg::ST_RESET)
                wdt_cnt_q <= 32'h0000_0000;
            else if (wdt_cnt_q != WDT_LIMIT)
                wdt_cnt_q <= wdt_cnt_q + 32'h0000_0001;
        end
    end

    // reset output driven high while the next state is reset, for the whole pulse
    always_ff @(posedge clk_sys) begin
        if (!rstn)
            reset_out <= 1'b1;
        else
            reset_out <= (state_d == supervisor_pkg::ST_RESET);
    end

    // configuration returns to default on any initialization
    always_ff @(posedge clk_sys) begin
        if (init_now)
            cfg_value <= `CFG_DEFAULT;
        else if (cfg_wr)
            cfg_value <= cfg_wdata;
    end

    // result-valid flag after settling
    always_ff @(posedge clk_sys) begin
        if (init_now || state_q == supervisor_pkg::ST_RESET) begin
            settle_cnt_q <= 16'h0000;
            valid_q      <= 1'b0;
        end else begin
            if (settle_cnt_q != 16'hffff)
                settle_cnt_q <= settle_cnt_q + 16'h0001;
            if (state_q == supervisor_pkg::ST_SETTLE && settle_done)
                valid_q <= 1'b1;
        end
    end

    // status byte: bit0 valid, bit1 in reset
    always_ff @(posedge clk_sys) begin
        if (!rstn)
            conversion_status_byte <= 8'h00;
        else
            conversion_status_byte <= {6'h00, state_q == supervisor_pkg::ST_RESET, valid_q};
    end

    // length of the current reset pulse, used only by the minimum-length check chk_pulse_min
    logic [4:0] rst_len_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn || !reset_out)
            rst_len_q <= 5'h00;
        else if (rst_len_q != 5'h1f)
            rst_len_q <= rst_len_q + 5'h01;
    end

    // checks: all quiet while rstn is low; they look at what this block drives
    // or decides. the pulse is longer than a repetition should spell out, so its
    // full length is checked through the small counter above.

    // reset requests
    chk_wdt_fires: assert property (@(posedge clk_sys) disable iff (!rstn)
        wdt_expired && state_q != supervisor_pkg::ST_RESET |=> reset_out)
        else $error("watchdog expiry did not raise reset");
    chk_rise_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(reset_out) |-> $past(brownout) || $past(wdt_expired))
        else $error("reset raised without a cause");
    chk_wdt_init_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        reset_in |=> wdt_cnt_q == 32'h0000_0000)
        else $error("watchdog count kept through init");
    chk_brownout_rst: assert property (@(posedge clk_sys) disable iff (!rstn)
        brownout |=> reset_out)
        else $error("brownout did not raise reset");
    chk_brownout_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        brownout && state_q == supervisor_pkg::ST_RESET |=> state_q == supervisor_pkg::ST_RESET)
        else $error("reset left during brownout");
    chk_rst_release: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(reset_out) |-> !$past(brownout, 2))
        else $error("reset released during brownout");
    chk_status_rst: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == supervisor_pkg::ST_RESET |=> conversion_status_byte[1])
        else $error("status does not show reset");

    // watchdog service
    chk_strobe_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
        wdt_strobe && !brownout && state_q != supervisor_pkg::ST_RESET |=> !reset_out)
        else $error("strobed watchdog caused reset");
    chk_wdt_count: assert property (@(posedge clk_sys) disable iff (!rstn)
        wdt_strobe |=> wdt_cnt_q == 32'h0000_0000)
        else $error("strobe did not restart watchdog");
    chk_wdt_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
        wdt_cnt_q <= WDT_LIMIT)
        else $error("watchdog count past its limit");

    // pulse and init
    chk_pulse_len: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(reset_out) |-> reset_out [*8])
        else $error("reset pulse too short");
    chk_pulse_min: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(reset_out) |-> $past(rst_len_q) >= PULSE_LAST)
        else $error("reset pulse shorter than its count");
    chk_reset_state: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == supervisor_pkg::ST_RESET |-> reset_out)
        else $error("reset state without reset output");
    chk_init_valid: assert property (@(posedge clk_sys) disable iff (!rstn)
        reset_in |=> !valid_q)
        else $error("valid kept through init");

    // configuration
    chk_cfg_default: assert property (@(posedge clk_sys) disable iff (!rstn)
        reset_in |=> cfg_value == `CFG_DEFAULT)
        else $error("configuration not restored");
    chk_cfg_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        cfg_wr && !init_now |=> cfg_value == $past(cfg_wdata))
        else $error("configuration write lost");
    chk_cfg_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        !cfg_wr && !init_now |=> $stable(cfg_value))
        else $error("configuration changed without a write");

    // result valid
    chk_valid_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        reset_out |-> ##2 conversion_status_byte[0] == 1'b0)
        else $error("valid flag set during reset");
    chk_valid_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(valid_q) |-> $past(data_ready))
        else $error("valid without ready data");
    chk_valid_early: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(valid_q) |-> $past(settle_cnt_q) >= $past(settle_cycles))
        else $error("valid before settling ended");
    chk_valid_state: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(valid_q) |-> $past(state_q) == supervisor_pkg::ST_SETTLE)
        else $error("valid set outside settling");
    chk_settle_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
        reset_in |=> settle_cnt_q == 16'h0000)
        else $error("settling not restarted by init");
    chk_status_pad: assert property (@(posedge clk_sys) disable iff (!rstn)
        conversion_status_byte[7:2] == 6'h00)
        else $error("unused status bits set");

    // main scenarios
    cov_wdt_reset: cover property (@(posedge clk_sys) disable iff (!rstn) wdt_expired);
    cov_brownout: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(brownout));
    cov_valid: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(valid_q));
    cov_ext_init: cover property (@(posedge clk_sys) disable iff (!rstn) reset_in && !reset_out);
    cov_rearm: cover property (@(posedge clk_sys) disable iff (!rstn) $fell(reset_out));
endmodule

// File: verif/fw_partner.sv
// firmware strobe source and reset loopback for the watchdog
module fw_partner #(parameter int PERIOD = 100) (
    input  wire logic clk_sys,
    input  wire logic run,
    input  wire logic reset_out,
    input  wire logic ext_reset,
    output logic      wdt_strobe,
    output logic      reset_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // reset output looped back, ored with the system reset
    assign reset_in = reset_out | ext_reset;
    // one-cycle strobe every PERIOD cycles while firmware runs
    always @(posedge clk_sys) begin
        cnt <= (cnt >= PERIOD - 1) ? 0 : cnt + 1;
        wdt_strobe <= run && (cnt == 0);
    end
endmodule

// File: verif/tb.sv
// self-checking bench for the supervisory reset watchdog
`include "supervisor_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rstn = 0, brownout = 0, ext_reset = 0, cfg_wr = 0, data_ready = 1, run = 0;
    logic [15:0] cfg_wdata = 16'h0000, settle_cycles = 16'h0020;
    logic wdt_strobe, reset_in, reset_out;
    logic [15:0] cfg_value;
    logic [7:0] status;
    int fails = 0, checks_done = 0;
    supervisor_reset_watchdog #(.WDT_TIMEOUT_CYC(200)) supervisor_reset_watchdog_inst (.clk_sys(clk_sys),
        .rstn(rstn), .wdt_strobe(wdt_strobe), .brownout(brownout), .reset_in(reset_in), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .settle_cycles(settle_cycles), .data_ready(data_ready),
        .reset_out(reset_out), .cfg_value(cfg_value), .conversion_status_byte(status));
    fw_partner #(.PERIOD(100)) fw_partner_inst (.clk_sys(clk_sys), .run(run), .reset_out(reset_out),
        .ext_reset(ext_reset), .wdt_strobe(wdt_strobe), .reset_in(reset_in));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // step n cycles, sampling after the edge has settled
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // bounded wait for reset_out to reach v
    task automatic wait_rst(logic v, int n);
        for (int i = 0; i < n && reset_out !== v; i++) cyc(1);
        chk("reset_out", {15'h0000, v}, {15'h0000, reset_out});
        if (reset_out !== v) end_sim();
    endtask
    task automatic wr_cfg(logic [15:0] d);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        cyc(2);
        chk("cfg_value", d, cfg_value);
    endtask
    // after a reset: defaults, valid low, then valid after settling
    task automatic post_reset();
        cyc(3);
        chk("cfg_value", `CFG_DEFAULT, cfg_value);
        chk("valid", 16'h0000, {15'h0000, status[0]});
        wait_rst(1'b0, 60);
        chk("valid", 16'h0000, {15'h0000, status[0]});
        cyc(40);
        chk("valid", 16'h0001, {15'h0000, status[0]});
    endtask
    task automatic test_boot();
        cyc(6);
        rstn <= 1'b1;
        post_reset();
        $display("boot test done");
    endtask
    task automatic test_service();
        int seen;
        seen = 0;
        run <= 1'b1;
        wr_cfg(16'h5a3c);
        for (int i = 0; i < 700; i++) begin
            cyc(1);
            seen |= reset_out;
        end
        chk("serviced reset_out", 16'h0000, seen[15:0]);
        $display("service test done");
    endtask
    task automatic test_expiry();
        run <= 1'b0;
        wait_rst(1'b1, 320);
        run <= 1'b1;
        post_reset();
        $display("expiry test done");
    endtask
    task automatic test_brownout();
        wr_cfg(16'hc3a5);
        @(posedge clk_sys);
        brownout <= 1'b1;
        wait_rst(1'b1, 3);
        cyc(30);
        chk("held reset_out", 16'h0001, {15'h0000, reset_out});
        chk("status", 16'h0002, {8'h00, status});
        brownout <= 1'b0;
        post_reset();
        $display("brownout test done");
    endtask
    task automatic test_ext_reset();
        wr_cfg(16'h0ff0);
        @(posedge clk_sys);
        ext_reset <= 1'b1;
        cyc(3);
        ext_reset <= 1'b0;
        post_reset();
        $display("external reset test done");
    endtask
    // valid must wait for ready data even after settling has run out
    task automatic test_data_ready();
        data_ready <= 1'b0;
        ext_reset <= 1'b1;
        cyc(3);
        ext_reset <= 1'b0;
        cyc(45);
        chk("valid", 16'h0000, {15'h0000, status[0]});
        data_ready <= 1'b1;
        cyc(3);
        chk("valid", 16'h0001, {15'h0000, status[0]});
        $display("data ready test done");
    endtask
    initial begin
        test_boot();
        test_service();
        test_expiry();
        test_brownout();
        test_ext_reset();
        test_data_ready();
        end_sim();
    end
endmodule
